// *** src/cmp_reference_ctrl.sv ***
// Comparator voltage reference control register with AXI4-Lite slave
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "external_ref_positive_cfg.svh"
// Overview of operation
// R1: Upper bits 15..11 read zero, writes to them ignored.
// R2: External select bit offers positive external ref, else ladder, when ref select set.
// R3: Band-gap field 00 gives band gap, 11 external positive; others reserved.
// R4: Enable bit powers the reference circuit on; clear powers it down.
// R5: Output-enable bit connects reference level to its dedicated pin.
// R6: Supply-select bit picks external ref pair or analog supply/ground.
// R7: Five-bit level code 0..31 forwarded to the ladder.
// R8: All control bits reset to zero: powered down and disconnected.
// R9: Software waits analog settling time after level changes.
// R10: Channel select 11 puts the band-gap-field reference on inverting input.
// R11: Writes update fields next edge; fields drive analog controls continuously. Here the controls are registered and follow the fields one edge later.
module cmp_reference_ctrl (
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [11:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        COMPARATOR_REF_SELECT,
  input  wire logic [1:0]  COMPARATOR_CHANNEL_SELECT,
  output logic             REF_POWER_ON,
  output logic             REF_PIN_CONNECT,
  output logic             LADDER_SUPPLY_EXTERNAL,
  output logic [4:0]       LADDER_LEVEL_CODE,
  output logic             NONINV_EXTERNAL_POS,
  output logic             NONINV_LADDER,
  output logic             INV_BANDGAP,
  output logic             INV_EXTERNAL_POS
);
  import ref_ctrl_pkg::*;

  logic        rst_meta_r;
  logic        rst_sync_r;
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic        aw_held_r;
  logic [11:0] aw_addr_r;
  logic        w_held_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        sel_r;
  logic [1:0]  ch_r;
  ladder_ctrl_t   ladder;
  cmp_ref_route_t route;

  // Reset release through two flops
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire logic rst_n = rst_sync_r;

  // Word-aligned register decode
  function automatic logic word_hit(input logic [11:0] addr, input logic [11:0] base);
    return addr[11:2] == base[11:2];
  endfunction

  // Write channel capture in either order
  wire logic aw_take   = S_AXI_AWVALID & S_AXI_AWREADY;
  wire logic w_take    = S_AXI_WVALID & S_AXI_WREADY;
  wire logic b_done    = S_AXI_BVALID & S_AXI_BREADY;
  wire logic wr_fire   = aw_held_r & w_held_r & ~S_AXI_BVALID;
  wire logic wr_hit    = word_hit(aw_addr_r, `CRC_ADDR_CTRL);
  wire logic wr_stat   = word_hit(aw_addr_r, `CRC_ADDR_STATUS);
  wire logic [15:0] lane_mask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  // R1 R11 masked update of implemented bits
  assign ctrl_nxt = (wr_fire & wr_hit)
                  ? (((ctrl_r & ~lane_mask) | (w_data_r[15:0] & lane_mask)) & `CRC_IMPL_MASK)
                  : ctrl_r;

  // Address held until the response is accepted
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_r     <= 1'b0;
      aw_addr_r     <= 12'h000;
      S_AXI_AWREADY <= 1'b0;
    end else begin
      S_AXI_AWREADY <= ~aw_held_r & ~aw_take;
      if (aw_take) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end else if (b_done) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  // Data held until the response is accepted
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      w_held_r     <= 1'b0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      S_AXI_WREADY <= 1'b0;
    end else begin
      S_AXI_WREADY <= ~w_held_r & ~w_take;
      if (w_take) begin
        w_held_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end else if (b_done) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Response once both halves are held
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `AXI_RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= (wr_hit | wr_stat) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (b_done) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // R8 reset to zero, powered down
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `CRC_RESET_VALUE;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Comparator selects come from the same clock domain
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      sel_r <= 1'b0;
      ch_r  <= 2'h0;
    end else begin
      sel_r <= COMPARATOR_REF_SELECT;
      ch_r  <= COMPARATOR_CHANNEL_SELECT;
    end
  end

  // Read channel: one read at a time
  wire logic ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
  wire logic rd_ctrl = word_hit(S_AXI_ARADDR, `CRC_ADDR_CTRL);
  wire logic rd_stat = word_hit(S_AXI_ARADDR, `CRC_ADDR_STATUS);
  wire logic [31:0] stat_word = {24'h00_0000, route.cmp_reserved, route.cmp_ref_bandgap,
                                 route.cmp_ref_extpos, route.cmp_ref_ladder,
                                 ladder.offer_external_pos, ch_r, sel_r};
  // R1 upper bits read as zero
  wire logic [31:0] rd_word = rd_ctrl ? {16'h0000, ctrl_r & `CRC_IMPL_MASK}
                            : rd_stat ? stat_word : 32'h0000_0000;

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `AXI_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= ~S_AXI_RVALID & ~ar_take & ~S_AXI_ARREADY;
      if (ar_take) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_word;
        S_AXI_RRESP  <= (rd_ctrl | rd_stat) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (S_AXI_RVALID & S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  ref_route_decode u_route (
    .ctrl_word                 (ctrl_r),
    .comparator_ref_select     (sel_r),
    .comparator_channel_select (ch_r),
    .ladder                    (ladder),
    .route                     (route)
  );

  // R4 R5 R6 R7 registered ladder controls
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      REF_POWER_ON           <= 1'b0;
      REF_PIN_CONNECT        <= 1'b0;
      LADDER_SUPPLY_EXTERNAL <= 1'b0;
      LADDER_LEVEL_CODE      <= 5'h00;
    end else begin
      REF_POWER_ON           <= ladder.power_on;
      REF_PIN_CONNECT        <= ladder.pin_connect;
      LADDER_SUPPLY_EXTERNAL <= ladder.supply_external;
      LADDER_LEVEL_CODE      <= ladder.level_code;
    end
  end

  // R2 R3 R10 registered comparator routing
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      NONINV_EXTERNAL_POS    <= 1'b0;
      NONINV_LADDER          <= 1'b0;
      INV_BANDGAP            <= 1'b0;
      INV_EXTERNAL_POS       <= 1'b0;
    end else begin
      NONINV_EXTERNAL_POS    <= ladder.offer_external_pos;
      NONINV_LADDER          <= route.cmp_ref_ladder;
      INV_BANDGAP            <= route.cmp_ref_bandgap;
      INV_EXTERNAL_POS       <= route.cmp_ref_extpos;
    end
  end
endmodule
`default_nettype wire

// *** src/external_ref_positive_cfg.svh ***
// Constants for the comparator reference control block
`ifndef REF_CTRL_CFG_SVH
`define REF_CTRL_CFG_SVH
`define CRC_ADDR_CTRL     12'h000
`define CRC_ADDR_STATUS   12'h004
`define CRC_IMPL_MASK     16'h07ff
`define CRC_RESET_VALUE   16'h0000
`define CRC_BIT_EXTSEL    10
`define CRC_BIT_BGSRC_HI  9
`define CRC_BIT_BGSRC_LO  8
`define CRC_BIT_PWR       7
`define CRC_BIT_PINOE     6
`define CRC_BIT_SUPPLY    5
`define CRC_BIT_LEVEL_HI  4
`define CRC_BIT_LEVEL_LO  0
`define CRC_CH_INTERNAL   2'h3
`define CRC_BG_BANDGAP    2'h0
`define CRC_BG_EXTPOS     2'h3
`define AXI_RESP_OKAY     2'h0
`define AXI_RESP_SLVERR   2'h2
`endif

// *** src/external_ref_positive_pkg.sv ***
// Types shared by the comparator reference control block
package ref_ctrl_pkg;
  typedef struct packed {
    logic       power_on;
    logic       pin_connect;
    logic       supply_external;
    logic [4:0] level_code;
    logic       offer_external_pos;
  } ladder_ctrl_t;
  typedef struct packed {
    logic       cmp_ref_bandgap;
    logic       cmp_ref_extpos;
    logic       cmp_ref_ladder;
    logic       cmp_reserved;
  } cmp_ref_route_t;
  typedef enum logic [1:0] {
    BGSRC_BANDGAP = 2'h0,
    BGSRC_RSV1    = 2'h1,
    BGSRC_RSV2    = 2'h2,
    BGSRC_EXTPOS  = 2'h3
  } bgsrc_t;
endpackage

// *** src/external_ref_positive_route.sv ***
// Decode of the comparator inverting/non-inverting reference route
`timescale 1ns/1ps
`default_nettype none
`include "external_ref_positive_cfg.svh"
module ref_route_decode (
  input  wire logic [15:0]                 ctrl_word,
  input  wire logic                        comparator_ref_select,
  input  wire logic [1:0]                  comparator_channel_select,
  output var ref_ctrl_pkg::ladder_ctrl_t   ladder,
  output var ref_ctrl_pkg::cmp_ref_route_t route
);
  import ref_ctrl_pkg::*;
  wire logic [1:0] bandgap_source_field = ctrl_word[`CRC_BIT_BGSRC_HI:`CRC_BIT_BGSRC_LO];
  wire logic       external_ref_select  = ctrl_word[`CRC_BIT_EXTSEL];
  wire logic       inv_internal         = comparator_channel_select == `CRC_CH_INTERNAL;
  // R4 R5 R6 R7: ladder controls
  assign ladder.power_on           = ctrl_word[`CRC_BIT_PWR];
  assign ladder.pin_connect        = ctrl_word[`CRC_BIT_PINOE];
  assign ladder.supply_external    = ctrl_word[`CRC_BIT_SUPPLY];
  assign ladder.level_code         = ctrl_word[`CRC_BIT_LEVEL_HI:`CRC_BIT_LEVEL_LO];
  // R2 non-inverting source select
  assign ladder.offer_external_pos = comparator_ref_select & external_ref_select;
  assign route.cmp_ref_ladder      = comparator_ref_select & ~external_ref_select;
  // R3 R10 inverting input band-gap source
  assign route.cmp_ref_bandgap = inv_internal & (bandgap_source_field == `CRC_BG_BANDGAP);
  assign route.cmp_ref_extpos  = inv_internal & (bandgap_source_field == `CRC_BG_EXTPOS);
  assign route.cmp_reserved    = inv_internal & (bandgap_source_field != `CRC_BG_BANDGAP)
                                 & (bandgap_source_field != `CRC_BG_EXTPOS);
endmodule
`default_nettype wire

// *** testbench/cmp_reference_ctrl_chk.sv ***
// Assertion checker for the comparator reference control block
`timescale 1ns/1ps
`default_nettype none
`include "external_ref_positive_cfg.svh"
module cmp_reference_ctrl_chk (
  input wire logic        CLOCK,
  input wire logic        RSTN,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        COMPARATOR_REF_SELECT,
  input wire logic [1:0]  COMPARATOR_CHANNEL_SELECT,
  input wire logic        REF_POWER_ON,
  input wire logic        REF_PIN_CONNECT,
  input wire logic        LADDER_SUPPLY_EXTERNAL,
  input wire logic [4:0]  LADDER_LEVEL_CODE,
  input wire logic        NONINV_EXTERNAL_POS,
  input wire logic        NONINV_LADDER,
  input wire logic        INV_BANDGAP,
  input wire logic        INV_EXTERNAL_POS
);
  logic [2:0]      up_r;
  logic            rd_ctrl_r;
  wire logic [7:0] outs = {REF_POWER_ON, REF_PIN_CONNECT, LADDER_SUPPLY_EXTERNAL,
                           LADDER_LEVEL_CODE};
  // Edges since reset release, and whether the pending read targets control
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      up_r      <= 3'h0;
      rd_ctrl_r <= 1'b0;
    end else begin
      up_r <= (up_r == 3'h7) ? up_r : up_r + 3'h1;
      if (S_AXI_ARVALID && S_AXI_ARREADY) rd_ctrl_r <= (S_AXI_ARADDR == `CRC_ADDR_CTRL);
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  sequence s_wr_take; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY; endsequence
  sequence s_rd_take; S_AXI_ARVALID && S_AXI_ARREADY; endsequence
  property p_wr_answer; s_wr_take |-> ##2 S_AXI_BVALID; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
  property p_rd_answer; s_rd_take |=> S_AXI_RVALID; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read response missing");
  property p_upper_zero; S_AXI_RVALID |-> S_AXI_RDATA[31:11] == 21'h0; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_reset_zero; (up_r <= 3'h2) |-> outs == 8'h00; endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("controls not off after reset");
  property p_hold_outs; !$past(S_AXI_BVALID) |-> $stable(outs); endproperty
  a_hold_outs: assert property (p_hold_outs) else $error("controls moved without write");
  property p_readback; $rose(S_AXI_RVALID) && rd_ctrl_r |-> S_AXI_RDATA[7:0] == outs; endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");
  property p_ref_route;
    (up_r == 3'h7) |-> !(NONINV_EXTERNAL_POS && NONINV_LADDER)
      && ((NONINV_EXTERNAL_POS || NONINV_LADDER) == $past(COMPARATOR_REF_SELECT, 2));
  endproperty
  a_ref_route: assert property (p_ref_route) else $error("non-inverting route wrong");
  property p_inv_route;
    (up_r == 3'h7) && (INV_BANDGAP || INV_EXTERNAL_POS)
      |-> $past(COMPARATOR_CHANNEL_SELECT, 2) == `CRC_CH_INTERNAL;
  endproperty
  a_inv_route: assert property (p_inv_route) else $error("inverting route without channel");
  property p_inv_excl; !(INV_BANDGAP && INV_EXTERNAL_POS); endproperty
  a_inv_excl: assert property (p_inv_excl) else $error("two inverting sources");
endmodule
bind cmp_reference_ctrl cmp_reference_ctrl_chk u_chk (.*);
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the comparator reference control block
`timescale 1ns/1ps
`default_nettype none
`include "external_ref_positive_cfg.svh"
module tb_top;
  logic        clock, awready, wready, bvalid, arready, rvalid, pw, pc, se, nxe, nxl, ibg, iex;
  logic        rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, ref_sel = 1'b0;
  logic [1:0]  chan_sel = 2'h0, bresp, rresp;
  logic [3:0]  wstrb = 4'h0;
  logic [4:0]  level;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] w;
  int          mismatches = 0, checks_done = 0, cycles = 0;
  localparam int SETTLE_CYCLES = 4;
  cmp_reference_ctrl DUT (
    .CLOCK(clock), .RSTN(rstn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .COMPARATOR_REF_SELECT(ref_sel), .COMPARATOR_CHANNEL_SELECT(chan_sel),
    .REF_POWER_ON(pw), .REF_PIN_CONNECT(pc), .LADDER_SUPPLY_EXTERNAL(se), .LADDER_LEVEL_CODE(level),
    .NONINV_EXTERNAL_POS(nxe), .NONINV_LADDER(nxl), .INV_BANDGAP(ibg), .INV_EXTERNAL_POS(iex));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic complete_run;
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] stat_exp(input logic [15:0] v);
    logic inv;
    inv = chan_sel == `CRC_CH_INTERNAL;
    return {24'h00_0000, inv && v[9:8] != `CRC_BG_BANDGAP && v[9:8] != `CRC_BG_EXTPOS,
            inv && v[9:8] == `CRC_BG_BANDGAP, inv && v[9:8] == `CRC_BG_EXTPOS,
            ref_sel & ~v[10], ref_sel & v[10], chan_sel, ref_sel};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge clock);
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clock); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock); while (!rvalid);
    rready <= 1'b0;
    chk("rdata", rdata, ed);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask
  task automatic outs(input logic [15:0] v);
    repeat (2) @(posedge clock);
    chk("ctl", {24'h0, pw, pc, se, level}, {24'h0, v[7:0]});
    chk("route", {28'h0, nxe, nxl, ibg, iex}, {28'h0, ref_sel & v[10], ref_sel & ~v[10],
        chan_sel == `CRC_CH_INTERNAL && v[9:8] == `CRC_BG_BANDGAP,
        chan_sel == `CRC_CH_INTERNAL && v[9:8] == `CRC_BG_EXTPOS});
  endtask
  task automatic do_reset;
    rstn <= 1'b0;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
  endtask
  initial begin
    do_reset();
    outs(16'h0000);
    rd(`CRC_ADDR_CTRL, 32'h0, `AXI_RESP_OKAY);
    for (int i = 0; i < 32; i++) begin
      w = {5'h00, i[0], i[2:1], i[3], i[4], i[0], i[4:0]};
      ref_sel  <= i[3];
      chan_sel <= i[4:3];
      wr(`CRC_ADDR_CTRL, w | 16'hf800, 4'h3, `AXI_RESP_OKAY);
      repeat (SETTLE_CYCLES) @(posedge clock);
      outs(w);
      rd(`CRC_ADDR_CTRL, {16'h0, w}, `AXI_RESP_OKAY);
      rd(`CRC_ADDR_STATUS, stat_exp(w), `AXI_RESP_OKAY);
    end
    wr(`CRC_ADDR_CTRL, 16'h0000, 4'h1, `AXI_RESP_OKAY);
    outs(16'h0700);
    wr(12'h010, 16'hffff, 4'h3, `AXI_RESP_SLVERR);
    wr(`CRC_ADDR_STATUS, 16'hffff, 4'h3, `AXI_RESP_OKAY);
    rd(`CRC_ADDR_STATUS, stat_exp(16'h0700), `AXI_RESP_OKAY);
    rd(12'h010, 32'h0, `AXI_RESP_SLVERR);
    rd(`CRC_ADDR_CTRL, 32'h0700, `AXI_RESP_OKAY);
    wr(`CRC_ADDR_CTRL, 16'h0000, 4'h2, `AXI_RESP_OKAY);
    outs(16'h0000);
    wr(`CRC_ADDR_CTRL, 16'h00ff, 4'h3, `AXI_RESP_OKAY);
    outs(16'h00ff);
    do_reset();
    outs(16'h0000);
    rd(`CRC_ADDR_CTRL, 32'h0, `AXI_RESP_OKAY);
    complete_run();
  end
endmodule
`default_nettype wire
